/* shared/branch_bitset_pkg.sv */
package branch_bitset_pkg;
  localparam int PC_W       = 21;
  localparam int WORD_W     = 16;
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 8;
  localparam int BANK_W     = 4;
  localparam int LONG_OFF_W = 11;
  localparam int SHORT_OFF_W = 8;

  // Opcode fields.
  localparam logic [3:0] OPC_JUMP_HI   = 4'hD;
  localparam logic       OPC_JUMP_BIT  = 1'b0;
  localparam logic [3:0] OPC_BITSET_HI = 4'h8;
  localparam logic [7:0] OPC_NOV       = 8'hE5;
  localparam logic [7:0] OPC_NZ        = 8'hE1;

  localparam int OP_HI_MSB   = 15;
  localparam int OP_HI_LSB   = 12;
  localparam int OP_JUMP_BIT = 11;
  localparam int BITPOS_LSB  = 9;
  localparam int BANK_FLAG   = 8;

  // Access bank: low half maps to bank 0, upper half to bank 15.
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK  = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [DATA_W-1:0] ACCESS_SPLIT     = 8'h80;

  localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [1:0]      Q_LAST   = 2'h3;

  typedef enum logic [2:0] {
    OP_NONE, OP_JUMP, OP_NOV, OP_NZ, OP_BITSET
  } op_kind_t;
endpackage

/* shared/decode_if.sv */
`timescale 1ns/100ps
interface decode_if;
  import branch_bitset_pkg::*;
  op_kind_t                   kind;
  logic [PC_W-1:0]            offset;
  logic [2:0]                 bit_pos;
  logic                       use_bank_reg;
  logic [DATA_W-1:0]          reg_addr;
  modport dec (output kind, output offset, output bit_pos,
               output use_bank_reg, output reg_addr);
  modport exe (input kind, input offset, input bit_pos,
               input use_bank_reg, input reg_addr);
endinterface

/* design/instr_decoder.sv */
`timescale 1ns/100ps
module instr_decoder
  import branch_bitset_pkg::*;
(
  // Fetched word.
  input  wire logic [WORD_W-1:0] instr,
  // Decoded fields.
  decode_if.dec                  dec
);
  import branch_bitset_pkg::*;

  always_comb begin
    dec.kind     = OP_NONE;
    dec.offset   = '0;
    dec.bit_pos  = instr[BITPOS_LSB+2:BITPOS_LSB];
    dec.use_bank_reg = instr[BANK_FLAG];
    dec.reg_addr = instr[DATA_W-1:0];
    if (instr[OP_HI_MSB:OP_HI_LSB] == OPC_JUMP_HI &&
        instr[OP_JUMP_BIT] == OPC_JUMP_BIT) begin
      dec.kind   = OP_JUMP;
      // Sign-extend and double the 11-bit operand.
      dec.offset = PC_W'({{(PC_W-LONG_OFF_W-1){instr[LONG_OFF_W-1]}},
                          instr[LONG_OFF_W-1:0], 1'b0});
    end else if (instr[OP_HI_MSB:OP_HI_LSB] == OPC_BITSET_HI) begin
      dec.kind = OP_BITSET;
    end else if (instr[WORD_W-1:SHORT_OFF_W] == OPC_NOV ||
                 instr[WORD_W-1:SHORT_OFF_W] == OPC_NZ) begin
      dec.kind   = (instr[WORD_W-1:SHORT_OFF_W] == OPC_NOV) ?
                   OP_NOV : OP_NZ;
      dec.offset = PC_W'({{(PC_W-SHORT_OFF_W-1){instr[SHORT_OFF_W-1]}},
                          instr[SHORT_OFF_W-1:0], 1'b0});
    end
  end
endmodule

/* design/branch_and_bit_set_execute.sv */
`timescale 1ns/100ps
// Function
// - Relative jump adds twice a signed 11-bit operand to the fetch address plus 2.
// - Target is own address plus 2 plus twice the operand.
// - Relative jump decoded from 1101 then 0, 11-bit offset.
// - Relative jump: one word, two cycles, counter written in Q4.
// - Bit set forces one bit to one by read-modify-write.
// - Bit set decoded from 1000, bit field, bank flag, address.
// - Bank flag 0 uses access bank, 1 uses bank select register.
// - No-overflow jump taken only when overflow flag is zero.
// - Nonzero jump taken only when zero flag is zero.
module branch_and_bit_set_execute
  import branch_bitset_pkg::*;
(
  // Clock and reset.
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  // Instruction and phase.
  input  wire logic [WORD_W-1:0]        instr,
  input  wire logic                     instr_valid,
  input  wire logic [1:0]               q_phase,
  // Status and bank select.
  input  wire logic                     flag_overflow,
  input  wire logic                     flag_zero,
  input  wire logic [BANK_W-1:0]        bank_select_reg,
  // Data memory.
  output logic      [ADDR_W-1:0]        mem_addr,
  input  wire logic [DATA_W-1:0]        mem_rdata,
  output logic      [DATA_W-1:0]        mem_wdata,
  output logic                          mem_we,
  // Program counter and bubble flag.
  output logic      [PC_W-1:0]          pc,
  output logic                          bubble
);
  import branch_bitset_pkg::*;

  decode_if dbus ();
  logic [PC_W-1:0]   fetch_addr;
  logic              taken;
  logic [BANK_W-1:0] bank;
  logic              q4;

  instr_decoder u_dec (
    .instr (instr),
    .dec   (dbus)
  );

  assign q4 = (q_phase == Q_LAST);

  always_comb begin
    case (dbus.kind)
      OP_JUMP: taken = 1'b1;
      OP_NOV:  taken = !flag_overflow;
      OP_NZ:   taken = !flag_zero;
      default: taken = 1'b0;
    endcase
  end

  always_comb begin
    if (dbus.use_bank_reg) begin
      bank = bank_select_reg;
    end else if (dbus.reg_addr < ACCESS_SPLIT) begin
      bank = ACCESS_LOW_BANK;
    end else begin
      bank = ACCESS_HIGH_BANK;
    end
  end

  // The word address is combinational so the read returns within the cycle.
  assign mem_addr = {bank, dbus.reg_addr};

  // Counter holds the fetched word's address plus 2, or that address itself
  // right after reset or a taken branch; a bubble cycle executes nothing.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pc         <= PC_RESET;
      fetch_addr <= PC_RESET;
      bubble     <= 1'b0;
    end else if (instr_valid && q4) begin
      if (bubble) begin
        bubble <= 1'b0;
      end else if (taken) begin
        pc     <= fetch_addr + PC_STEP + dbus.offset;
        fetch_addr <= fetch_addr + PC_STEP + dbus.offset;
        bubble <= 1'b1;
      end else begin
        pc         <= fetch_addr + PC_STEP + PC_STEP;
        fetch_addr <= fetch_addr + PC_STEP;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mem_we    <= 1'b0;
      mem_wdata <= '0;
    end else begin
      mem_we <= 1'b0;
      if (instr_valid && !bubble && dbus.kind == OP_BITSET &&
          q_phase == Q_LAST - 2'h1) begin
        mem_wdata <= mem_rdata | DATA_W'(1 << dbus.bit_pos);
        mem_we    <= 1'b1;
      end
    end
  end
endmodule

/* tb/branch_and_bit_set_monitor.sv */
`timescale 1ns/100ps
module branch_and_bit_set_monitor
  import branch_bitset_pkg::*;
(
  // Control.
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  input  wire logic                instr_valid,
  input  wire logic                flag_overflow,
  input  wire logic                flag_zero,
  input  wire logic                mem_we,
  input  wire logic                bubble,
  // Buses.
  input  wire logic [WORD_W-1:0]   instr,
  input  wire logic [1:0]          q_phase,
  input  wire logic [BANK_W-1:0]   bank_select_reg,
  input  wire logic [ADDR_W-1:0]   mem_addr,
  input  wire logic [DATA_W-1:0]   mem_rdata,
  input  wire logic [DATA_W-1:0]   mem_wdata,
  input  wire logic [PC_W-1:0]     pc
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire go = instr_valid && !bubble;
  wire jmp = go && q_phase == 2'h3 && instr[15:11] == 5'h1A;
  wire cnd = go && q_phase == 2'h3 && (instr[15:8] & 8'hFB) == OPC_NZ;
  wire tk = instr[10] ? !flag_overflow : !flag_zero;
  wire bs = go && q_phase == 2'h2 && instr[15:12] == OPC_BITSET_HI;
  wire [PC_W-1:0] jo = {{9{instr[10]}}, instr[10:0], 1'h0};
  wire [PC_W-1:0] co = {{12{instr[7]}}, instr[7:0], 1'h0};
  // The counter shows the fetched word's address plus 2, except right
  // after reset or a taken branch, when it shows that address itself.
  logic at_tgt;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      at_tgt <= 1'h1;
    end else if (go && q_phase == 2'h3) begin
      at_tgt <= jmp || (cnd && tk);
    end
  end
  wire [PC_W-1:0] here = at_tgt ? pc : pc - PC_STEP;
  sequence s_bub; bubble [*4] ##1 !bubble; endsequence
  a_jump_target: assert property (
    jmp |=> pc == $past(here) + PC_STEP + $past(jo) ##0 s_bub)
    else $error("bad jump");
  a_cond_taken: assert property (
    cnd && tk |=> pc == $past(here) + PC_STEP + $past(co) ##0 s_bub)
    else $error("bad b");
  a_cond_skip: assert property (
    cnd && !tk |=> pc == $past(here) + PC_STEP + PC_STEP && !bubble)
    else $error("bad s");
  a_set_write: assert property (bs |=> mem_we &&
    mem_wdata == ($past(mem_rdata) | 8'h01 << $past(instr[11:9])))
    else $error("bad write");
  a_write_cause: assert property (
    mem_we |-> $past(bs) ##1 !mem_we) else $error("stray write");
  a_bank_pick: assert property (bs |-> mem_addr == {
    instr[8] ? bank_select_reg : {4{instr[7]}}, instr[7:0]})
    else $error("bad address");
  a_bubble_hold: assert property (
    bubble |=> $stable(pc) && !mem_we) else $error("bubble not idle");
  a_pc_quiet: assert property (
    !(go && q_phase == 2'h3) |=> $stable(pc)) else $error("pc moved");
endmodule
bind branch_and_bit_set_execute branch_and_bit_set_monitor mon (.core_clk,
  .reset_n, .instr_valid, .flag_overflow, .flag_zero, .mem_we, .bubble,
  .instr, .q_phase, .bank_select_reg, .mem_addr, .mem_rdata, .mem_wdata, .pc);

/* tb/branch_and_bit_set_execute_tb_top.sv */
`timescale 1ns/100ps
module branch_and_bit_set_execute_tb_top;
  import branch_bitset_pkg::*;
  logic core_clk = 1'h0, reset_n = 1'h0, instr_valid = 1'h1;
  logic flag_overflow = 1'h0, flag_zero = 1'h0;
  logic        mem_we, bubble;
  logic [1:0]  q_phase = 2'h0;
  logic [3:0]  bank_select_reg = 4'h5;
  logic [7:0]  mem_rdata = 8'h0A, mem_wdata, wd;
  logic [15:0] instr = 16'h0000;
  logic [11:0] mem_addr, ad;
  // Base models the fetch address of the word about to run.
  logic [20:0] pc, exp_pc, base = 21'h000000;
  int failures = 0, cmp_count = 0;
  always #5 core_clk = ~core_clk;
  branch_and_bit_set_execute dut (.core_clk, .reset_n, .instr,
    .instr_valid, .q_phase, .flag_overflow, .flag_zero,
    .bank_select_reg, .mem_addr, .mem_rdata, .mem_wdata, .mem_we, .pc,
    .bubble);
  task chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Runs one instruction cycle and captures the Q3 write.
  task cyc(input logic [15:0] w);
    instr = w;
    for (int i = 0; i < 4; i++) begin
      q_phase = 2'(i);
      @(negedge core_clk);
      if (i == 2) begin
        ad = mem_addr;
        wd = mem_we ? mem_wdata : 8'h00;
      end
    end
  endtask
  task t_jump(input logic [10:0] n);
    exp_pc = PC_W'(base + PC_STEP + {{9{n[10]}}, n, 1'h0});
    cyc({5'h1A, n});
    chk(pc, exp_pc);
    chk(bubble, 1'h1);
    base = exp_pc;
    cyc(16'h8F12);
    chk(pc, exp_pc);
    chk(wd, 8'h00);
    chk(bubble, 1'h0);
  endtask
  task t_cond(input logic [7:0] op, input logic ov, z, tk);
    flag_overflow = ov;
    flag_zero = z;
    exp_pc = PC_W'(base + PC_STEP + (tk ? 21'h1FFF00 : PC_STEP));
    cyc({op, 8'h80});
    chk(pc, exp_pc);
    chk(bubble, tk);
    base = tk ? exp_pc : PC_W'(base + PC_STEP);
    if (tk) begin
      cyc(16'h0000);
      chk(pc, exp_pc);
      chk(bubble, 1'h0);
    end
  endtask
  task t_set(input logic [2:0] b, input logic a, input logic [7:0] f,
             input logic [3:0] bk);
    exp_pc = PC_W'(base + PC_STEP + PC_STEP);
    cyc({4'h8, b, a, f});
    chk(ad, {bk, f});
    chk(wd, 8'h0A | 8'h01 << b);
    chk(pc, exp_pc);
    base = PC_W'(base + PC_STEP);
  endtask
  // Words offered while instr_valid is low must change nothing.
  task t_idle;
    instr_valid = 1'h0;
    cyc(16'h8F12);
    chk(wd, 8'h00);
    cyc(16'hD001);
    chk(pc, exp_pc);
    chk(bubble, 1'h0);
    instr_valid = 1'h1;
  endtask
  task end_of_test;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    reset_n = 1'h1;
    t_jump(11'h3FF);
    t_jump(11'h400);
    t_cond(8'hE5, 0, 1, 1);
    t_cond(8'hE5, 1, 0, 0);
    t_cond(8'hE1, 1, 0, 1);
    t_cond(8'hE1, 0, 1, 0);
    t_set(3'h7, 1, 8'h12, 4'h5);
    t_set(3'h0, 0, 8'h7F, 4'h0);
    t_set(3'h4, 0, 8'h80, 4'hF);
    t_idle;
    end_of_test;
  end
  initial begin
    #5000;
    failures++;
    end_of_test;
  end
endmodule
